// >>> rtl/gmia_pkg.sv
package gmia_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int PIN_COUNT = 40;
   localparam int CHAN_COUNT = 4;
   localparam int CH_VOUT_COUNT = 8;
   localparam int CH_OUT_FUNC_COUNT = 16;
   localparam int CH_IN_FUNC_COUNT = 8;
   localparam int GLB_IN_FUNC_COUNT = 4;
   localparam int IN_SEL_COUNT = CHAN_COUNT * CH_IN_FUNC_COUNT + GLB_IN_FUNC_COUNT;
   localparam int VOUT_COUNT = CHAN_COUNT * CH_VOUT_COUNT;
   localparam int CH_SRC_COUNT = 8;
   localparam int CH_GEN_COUNT = 2;
   localparam int TIMING_INST_COUNT = 2;
   localparam int AGG_COUNT = 4;
   localparam int CHIP_SRC_COUNT = 17;

   // ----------------------------------------------------------------
   // Selector encodings
   // ----------------------------------------------------------------
   localparam logic [5:0] IN_SEL_ZERO = 6'h00;
   localparam logic [5:0] IN_SEL_ONE = 6'h01;
   localparam logic [5:0] IN_SEL_PIN0 = 6'h02;
   localparam logic [5:0] OUT_SEL_OFF = 6'h00;
   localparam logic [5:0] OUT_SEL_LOW = 6'h01;
   localparam logic [5:0] OUT_SEL_HIGH = 6'h02;
   localparam logic [5:0] OUT_SEL_AGG0 = 6'h03;
   localparam logic [5:0] OUT_SEL_MGMT_DATA = 6'h07;
   localparam logic [5:0] OUT_SEL_VOUT0 = 6'h08;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam int GLB_MGMT_DATA_IN = 0;
   localparam int GLB_MGMT_CLK_IN = 1;
   localparam int MGMT_DATA_PIN = 32;
   localparam logic [5:0] RST_IN_SEL_MGMT_DATA = 6'h22;
   localparam logic [5:0] RST_IN_SEL_MGMT_CLK = 6'h23;
   localparam logic [5:0] RST_OUT_SEL_MGMT = OUT_SEL_MGMT_DATA;

   // ----------------------------------------------------------------
   // Register word indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_LEVEL_LO = 10'h000;
   localparam logic [9:0] IDX_LEVEL_HI = 10'h001;
   localparam logic [9:0] IDX_CHANGE_LO = 10'h002;
   localparam logic [9:0] IDX_CHANGE_HI = 10'h003;
   localparam logic [9:0] IDX_PIN_IRQ_EN_LO = 10'h004;
   localparam logic [9:0] IDX_PIN_IRQ_EN_HI = 10'h005;
   localparam logic [9:0] IDX_AGG_EN = 10'h008;
   localparam logic [9:0] IDX_AGG_STATUS = 10'h00C;
   localparam logic [9:0] IDX_CH_EN = 10'h010;
   localparam logic [9:0] IDX_CH_STATUS = 10'h014;
   localparam logic [9:0] IDX_AGG_STATE = 10'h018;
   localparam logic [9:0] IDX_OUT_SEL = 10'h040;
   localparam logic [9:0] IDX_IN_SEL = 10'h080;
   localparam logic [9:0] IDX_VOUT_SEL = 10'h0C0;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic primed;
      logic [PIN_COUNT-1:0] pin_prev;
      logic [PIN_COUNT-1:0] change;
      logic [PIN_COUNT-1:0] pin_irq_en;
      logic [AGG_COUNT-1:0][CHIP_SRC_COUNT-1:0] agg_en;
      logic [CHAN_COUNT-1:0][CH_GEN_COUNT-1:0][CH_SRC_COUNT-1:0] ch_en;
      logic [PIN_COUNT-1:0][5:0] out_sel;
      logic [IN_SEL_COUNT-1:0][5:0] in_sel;
      logic [VOUT_COUNT-1:0][3:0] vout_sel;
      logic [PIN_COUNT-1:0] pin_oe;
      logic [PIN_COUNT-1:0] pin_out;
      logic [CHAN_COUNT*CH_IN_FUNC_COUNT-1:0] ch_in_func;
      logic [GLB_IN_FUNC_COUNT-1:0] glb_in_func;
      logic [AGG_COUNT-1:0] agg_irq;
   } gmia_state_type;

endpackage

// >>> rtl/gmia_top.sv
`timescale 1ns/1ns
// Functional notes
// - Forty pins; any channel or global function maps onto any pin.
// - Pins are open-drain: drive low or release; external pull-up gives high.
// - Every input function selects any pin, constant zero or constant one.
// - Reset routes pin 32 to slave data input, pin 33 to slave clock.
// - Software reads present level of every pin at any time.
// - One sticky change flag per pin, set on any change, held until cleared.
// - Eight output selectors per channel pick channel functions onto virtual outputs.
// - Per-pin selector picks virtual output or chip-level function such as interrupt.
// - Pin output selector also forces constant low or constant high.
// - After reset all pin outputs disabled except pin 32, slave data output.
// - Each channel source feeds two generators, each with its own enable.
// - Masked status of each channel source stays readable.
// - Chip sources: two interrupts, two buffer status per timing instance, cross-connect.
// - Any pin change can raise a chip-level interrupt.
// - Chip and eight channel interrupts feed four aggregators, masked each, status readable.
// - Pin-change sources share one enable mask across all four aggregators.
// - Any pin may output the state of any of the four aggregates.
module gmia_top (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [39:0] pin_in,
   output logic [39:0] pin_out,
   output logic [39:0] pin_oe,
   input wire logic [63:0] ch_out_func,
   output logic [31:0] ch_in_func,
   output logic [3:0] glb_in_func,
   input wire logic mgmt_slave_data_out,
   input wire logic [31:0] ch_irq_src,
   input wire logic [3:0] timing_irq,
   input wire logic [3:0] timing_buf_status,
   input wire logic xconn_irq,
   output logic [3:0] agg_irq
);

   // ----------------------------------------------------------------
   // State and working signals
   // ----------------------------------------------------------------
   gmia_pkg::gmia_state_type cur;
   gmia_pkg::gmia_state_type nxt;

   logic [gmia_pkg::VOUT_COUNT-1:0] vout;
   logic [7:0] ch_gen_irq;
   logic [gmia_pkg::CHAN_COUNT-1:0][gmia_pkg::CH_GEN_COUNT-1:0][7:0] ch_masked;
   logic [gmia_pkg::CHIP_SRC_COUNT-1:0] chip_src;
   logic [gmia_pkg::AGG_COUNT-1:0][gmia_pkg::CHIP_SRC_COUNT:0] agg_masked;
   logic [gmia_pkg::PIN_COUNT-1:0] pin_chg_masked;
   logic [gmia_pkg::PIN_COUNT-1:0] change_evt;
   logic [gmia_pkg::PIN_COUNT-1:0] change_clr;
   logic [31:0] rdata;
   logic rhit;
   logic [9:0] idx;
   logic wr_commit;
   logic [5:0] sel;
   logic [5:0] pidx;
   logic [5:0] vidx;
   logic lvl;
   logic drive;
   logic [1:0] sub_idx;
   logic hit_agg_en;
   logic hit_agg_status;
   logic hit_ch_en;
   logic hit_ch_status;
   logic hit_out_sel;
   logic hit_in_sel;
   logic hit_vout_sel;
   logic clr_change_lo;
   logic clr_change_hi;
   logic [9:0] out_idx;
   logic [9:0] in_idx;
   logic [9:0] vout_idx;

   // ----------------------------------------------------------------
   // Outputs, all registered
   // ----------------------------------------------------------------
   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = cur.pslverr;
   assign pin_out = cur.pin_out;
   assign pin_oe = cur.pin_oe;
   assign ch_in_func = cur.ch_in_func;
   assign glb_in_func = cur.glb_in_func;
   assign agg_irq = cur.agg_irq;

   always_comb begin
      nxt = cur;
      idx = paddr[11:2];
      // A write takes effect at the edge that sees pready high
      wr_commit = psel && penable && pwrite && cur.pready;

      // ----------------------------------------------------------------
      // Register window decode
      // ----------------------------------------------------------------
      sub_idx = idx[1:0];
      hit_agg_en = idx >= gmia_pkg::IDX_AGG_EN && idx < gmia_pkg::IDX_AGG_EN + 10'd4;
      hit_agg_status = idx >= gmia_pkg::IDX_AGG_STATUS && idx < gmia_pkg::IDX_AGG_STATUS + 10'd4;
      hit_ch_en = idx >= gmia_pkg::IDX_CH_EN && idx < gmia_pkg::IDX_CH_EN + 10'd4;
      hit_ch_status = idx >= gmia_pkg::IDX_CH_STATUS && idx < gmia_pkg::IDX_CH_STATUS + 10'd4;
      hit_out_sel = idx >= gmia_pkg::IDX_OUT_SEL && idx < gmia_pkg::IDX_OUT_SEL + 10'd40;
      hit_in_sel = idx >= gmia_pkg::IDX_IN_SEL && idx < gmia_pkg::IDX_IN_SEL + 10'd36;
      hit_vout_sel = idx >= gmia_pkg::IDX_VOUT_SEL && idx < gmia_pkg::IDX_VOUT_SEL + 10'd32;
      clr_change_lo = wr_commit && idx == gmia_pkg::IDX_CHANGE_LO;
      clr_change_hi = wr_commit && idx == gmia_pkg::IDX_CHANGE_HI;
      out_idx = idx - gmia_pkg::IDX_OUT_SEL;
      in_idx = idx - gmia_pkg::IDX_IN_SEL;
      vout_idx = idx - gmia_pkg::IDX_VOUT_SEL;

      // ----------------------------------------------------------------
      // Channel virtual outputs and interrupt generators
      // ----------------------------------------------------------------
      // Virtual output v belongs to channel v / 8
      for (int v = 0; v < gmia_pkg::VOUT_COUNT; v++) begin
         vout[v] = ch_out_func[(v / gmia_pkg::CH_VOUT_COUNT) * gmia_pkg::CH_OUT_FUNC_COUNT
                               + int'(cur.vout_sel[v])];
      end
      for (int c = 0; c < gmia_pkg::CHAN_COUNT; c++) begin
         for (int g = 0; g < gmia_pkg::CH_GEN_COUNT; g++) begin
            ch_masked[c][g] = ch_irq_src[c*8 +: 8] & cur.ch_en[c][g];
            ch_gen_irq[c*2+g] = |ch_masked[c][g];
         end
      end

      // ----------------------------------------------------------------
      // Aggregators
      // ----------------------------------------------------------------
      chip_src = {xconn_irq, timing_buf_status, timing_irq, ch_gen_irq};
      pin_chg_masked = cur.change & cur.pin_irq_en;
      // One pin-change mask is shared by every aggregator
      for (int a = 0; a < gmia_pkg::AGG_COUNT; a++) begin
         agg_masked[a] = {|pin_chg_masked, chip_src & cur.agg_en[a]};
         nxt.agg_irq[a] = |agg_masked[a];
      end

      // ----------------------------------------------------------------
      // Input function selectors
      // ----------------------------------------------------------------
      // Codes past the last pin fall back to constant zero
      for (int i = 0; i < gmia_pkg::IN_SEL_COUNT; i++) begin
         sel = cur.in_sel[i];
         pidx = sel - gmia_pkg::IN_SEL_PIN0;
         if (sel == gmia_pkg::IN_SEL_ONE) begin
            lvl = 1'b1;
         end else if (sel >= gmia_pkg::IN_SEL_PIN0 && pidx < 6'd40) begin
            lvl = pin_in[pidx];
         end else begin
            lvl = 1'b0;
         end
         if (i < gmia_pkg::CHAN_COUNT * gmia_pkg::CH_IN_FUNC_COUNT) begin
            nxt.ch_in_func[i] = lvl;
         end else begin
            nxt.glb_in_func[i - gmia_pkg::CHAN_COUNT * gmia_pkg::CH_IN_FUNC_COUNT] = lvl;
         end
      end

      // ----------------------------------------------------------------
      // Pin output selectors, open-drain drive
      // ----------------------------------------------------------------
      // Static high only releases the line; the pull-up gives the level
      for (int p = 0; p < gmia_pkg::PIN_COUNT; p++) begin
         sel = cur.out_sel[p];
         vidx = sel - gmia_pkg::OUT_SEL_VOUT0;
         drive = 1'b1;
         lvl = 1'b1;
         if (sel == gmia_pkg::OUT_SEL_OFF) begin
            drive = 1'b0;
         end else if (sel == gmia_pkg::OUT_SEL_LOW) begin
            lvl = 1'b0;
         end else if (sel == gmia_pkg::OUT_SEL_HIGH) begin
            lvl = 1'b1;
         end else if (sel < gmia_pkg::OUT_SEL_MGMT_DATA) begin
            lvl = cur.agg_irq[sel[1:0] - gmia_pkg::OUT_SEL_AGG0[1:0]];
         end else if (sel == gmia_pkg::OUT_SEL_MGMT_DATA) begin
            lvl = mgmt_slave_data_out;
         end else if (vidx < 6'd32) begin
            lvl = vout[vidx[4:0]];
         end else begin
            drive = 1'b0;
         end
         nxt.pin_out[p] = 1'b0;
         nxt.pin_oe[p] = drive & ~lvl;
      end

      // ----------------------------------------------------------------
      // Pin level sampling and change flags
      // ----------------------------------------------------------------
      // No history to compare against on the first sample after reset
      change_evt = cur.primed ? (pin_in ^ cur.pin_prev) : '0;
      change_clr = '0;
      if (clr_change_lo) begin
         change_clr[31:0] = pwdata;
      end
      if (clr_change_hi) begin
         change_clr[39:32] = pwdata[7:0];
      end
      // A change in the clearing cycle keeps its flag: set wins
      nxt.change = (cur.change & ~change_clr) | change_evt;
      nxt.pin_prev = pin_in;
      nxt.primed = 1'b1;

      // ----------------------------------------------------------------
      // Register read decode
      // ----------------------------------------------------------------
      rdata = '0;
      rhit = 1'b1;
      if (idx == gmia_pkg::IDX_LEVEL_LO) begin
         rdata = cur.pin_prev[31:0];
      end else if (idx == gmia_pkg::IDX_LEVEL_HI) begin
         rdata[7:0] = cur.pin_prev[39:32];
      end else if (idx == gmia_pkg::IDX_CHANGE_LO) begin
         rdata = cur.change[31:0];
      end else if (idx == gmia_pkg::IDX_CHANGE_HI) begin
         rdata[7:0] = cur.change[39:32];
      end else if (idx == gmia_pkg::IDX_PIN_IRQ_EN_LO) begin
         rdata = cur.pin_irq_en[31:0];
      end else if (idx == gmia_pkg::IDX_PIN_IRQ_EN_HI) begin
         rdata[7:0] = cur.pin_irq_en[39:32];
      end else if (hit_agg_en) begin
         rdata[16:0] = cur.agg_en[sub_idx];
      end else if (hit_agg_status) begin
         rdata[17:0] = agg_masked[sub_idx];
      end else if (hit_ch_en) begin
         rdata[15:0] = {cur.ch_en[sub_idx][1], cur.ch_en[sub_idx][0]};
      end else if (hit_ch_status) begin
         rdata[15:0] = {ch_masked[sub_idx][1], ch_masked[sub_idx][0]};
      end else if (idx == gmia_pkg::IDX_AGG_STATE) begin
         rdata[3:0] = cur.agg_irq;
      end else if (hit_out_sel) begin
         rdata[5:0] = cur.out_sel[out_idx];
      end else if (hit_in_sel) begin
         rdata[5:0] = cur.in_sel[in_idx];
      end else if (hit_vout_sel) begin
         rdata[3:0] = cur.vout_sel[vout_idx];
      end else begin
         rhit = 1'b0;
      end

      // ----------------------------------------------------------------
      // APB handshake: answer in the second access cycle
      // ----------------------------------------------------------------
      // Read data and error are latched at the first access edge
      if (psel && penable && !cur.pready) begin
         nxt.pready = 1'b1;
         nxt.pslverr = ~rhit;
         nxt.prdata = pwrite ? 32'h0000_0000 : rdata;
      end else begin
         nxt.pready = 1'b0;
         nxt.pslverr = 1'b0;
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (wr_commit) begin
         if (idx == gmia_pkg::IDX_PIN_IRQ_EN_LO) begin
            nxt.pin_irq_en[31:0] = pwdata;
         end else if (idx == gmia_pkg::IDX_PIN_IRQ_EN_HI) begin
            nxt.pin_irq_en[39:32] = pwdata[7:0];
         end else if (hit_agg_en) begin
            nxt.agg_en[sub_idx] = pwdata[16:0];
         end else if (hit_ch_en) begin
            nxt.ch_en[sub_idx][0] = pwdata[7:0];
            nxt.ch_en[sub_idx][1] = pwdata[15:8];
         end else if (hit_out_sel) begin
            nxt.out_sel[out_idx] = pwdata[5:0];
         end else if (hit_in_sel) begin
            nxt.in_sel[in_idx] = pwdata[5:0];
         end else if (hit_vout_sel) begin
            nxt.vout_sel[vout_idx] = pwdata[3:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
         // Management slave pins keep their default routing
         cur.in_sel[gmia_pkg::IN_SEL_COUNT-gmia_pkg::GLB_IN_FUNC_COUNT+gmia_pkg::GLB_MGMT_DATA_IN]
            <= gmia_pkg::RST_IN_SEL_MGMT_DATA;
         cur.in_sel[gmia_pkg::IN_SEL_COUNT-gmia_pkg::GLB_IN_FUNC_COUNT+gmia_pkg::GLB_MGMT_CLK_IN]
            <= gmia_pkg::RST_IN_SEL_MGMT_CLK;
         cur.out_sel[gmia_pkg::MGMT_DATA_PIN] <= gmia_pkg::RST_OUT_SEL_MGMT;
      end else begin
         cur <= nxt;
      end
   end

endmodule

// >>> test/gmia_pin_model.sv
`timescale 1ns/1ns
module gmia_pin_model (
   input wire logic [39:0] pin_oe,
   input wire logic [39:0] pin_out,
   input wire logic [39:0] ext_low,
   output logic [39:0] pin_level
);
   // ----------------------------------------------------------------
   // Pulled-up open-drain wires: any party pulling low wins
   // ----------------------------------------------------------------
   assign pin_level = ~(pin_oe & ~pin_out) & ~ext_low;
endmodule

// >>> test/gmia_chk.sv
`timescale 1ns/1ns
module gmia_chk (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [39:0] pin_in,
   input wire logic [39:0] pin_out,
   input wire logic [39:0] pin_oe,
   input wire logic [31:0] ch_in_func,
   input wire logic [3:0] glb_in_func,
   input wire logic mgmt_slave_data_out,
   input wire logic [3:0] agg_irq
);
   // ----------------------------------------------------------------
   // Set once software has written anything since reset
   // ----------------------------------------------------------------
   logic cfg_done;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_done <= 1'h0;
      end else if (psel && pwrite) begin
         cfg_done <= 1'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   chk_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   chk_one_wait: assert property (psel && !penable |-> !pready ##1 !pready ##1 pready)
      else $error("answer not in second access cycle");
   chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response without pready or with data");
   chk_open_drain: assert property (pin_out == 40'h0)
      else $error("pin driven high");
   chk_rst_data: assert property ($past(nrst) && !cfg_done |-> glb_in_func[0] == $past(pin_in[32]))
      else $error("slave data input not from pin 32");
   chk_rst_clock: assert property ($past(nrst) && !cfg_done |-> glb_in_func[1] == $past(pin_in[33]))
      else $error("slave clock input not from pin 33");
   chk_rst_oe: assert property ($past(nrst) && !cfg_done |->
      pin_oe == {7'h0, ~$past(mgmt_slave_data_out), 32'h0})
      else $error("default pin enables wrong");
   chk_ch_in_zero: assert property (!cfg_done |-> ch_in_func == 32'h0)
      else $error("channel inputs not constant zero by default");
   chk_agg_quiet: assert property (!cfg_done |-> agg_irq == 4'h0)
      else $error("aggregate raised with all enables clear");
endmodule
bind gmia_top gmia_chk i_gmia_chk (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .ch_in_func(ch_in_func), .glb_in_func(glb_in_func),
   .mgmt_slave_data_out(mgmt_slave_data_out), .agg_irq(agg_irq));

// >>> test/tb.sv
`timescale 1ns/1ns
module tb;
   logic core_clk = 1'h0;
   logic nrst = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, mgmt = 1'h1, xconn_irq = 1'h0;
   logic pready, pslverr, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, ch_irq_src = 32'h0, prdata, ch_in_func, rd;
   logic [39:0] ext_low = 40'h0, pin_in, pin_out, pin_oe;
   logic [63:0] ch_out_func = 64'h0;
   logic [3:0] timing_irq = 4'h0, timing_buf_status = 4'h0, glb_in_func, agg_irq;
   int errors = 0, check_count = 0, cycles = 0;
   always #25 core_clk = ~core_clk;
   gmia_top i_gmia_top (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .ch_out_func(ch_out_func), .ch_in_func(ch_in_func),
      .glb_in_func(glb_in_func), .mgmt_slave_data_out(mgmt), .ch_irq_src(ch_irq_src),
      .timing_irq(timing_irq), .timing_buf_status(timing_buf_status), .xconn_irq(xconn_irq), .agg_irq(agg_irq));
   gmia_pin_model i_gmia_pin_model (.pin_oe(pin_oe), .pin_out(pin_out), .ext_low(ext_low), .pin_level(pin_in));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'h1;
      do @(posedge core_clk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      apb(1'h1, idx, d);
   endtask
   task automatic rdchk(input string name, input logic [9:0] idx, input logic [31:0] exp);
      apb(1'h0, idx, 32'h0);
      chk(name, rd, exp);
   endtask
   task automatic conclude;
      $display("errors %0d, checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         conclude();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults;
      settle(1);
      chk("glb_in", glb_in_func[1:0], 2'h3);
      chk("oe_rst", pin_oe, 40'h0);
      @(posedge core_clk);
      mgmt <= 1'h0;
      settle(2);
      chk("oe_mgmt", pin_oe, 40'h01_0000_0000);
      chk("glb_data", glb_in_func[0], 1'h0);
      rdchk("lvl_lo", gmia_pkg::IDX_LEVEL_LO, 32'hFFFF_FFFF);
      rdchk("lvl_hi", gmia_pkg::IDX_LEVEL_HI, 32'hFE);
      mgmt <= 1'h1;
   endtask
   task automatic t_in_sel;
      ext_low[5] <= 1'h1;
      wr(gmia_pkg::IDX_IN_SEL + 10'h9, 32'(gmia_pkg::IN_SEL_ONE));
      settle(1);
      chk("in_one", ch_in_func[9], 1'h1);
      wr(gmia_pkg::IDX_IN_SEL + 10'h9, 32'(gmia_pkg::IN_SEL_PIN0 + 6'h5));
      settle(1);
      chk("in_pin", ch_in_func[9], 1'h0);
      @(posedge core_clk);
      ext_low[5] <= 1'h0;
      settle(2);
      chk("in_pin", ch_in_func[9], 1'h1);
      wr(gmia_pkg::IDX_IN_SEL + 10'h9, 32'(gmia_pkg::IN_SEL_ZERO));
      settle(1);
      chk("in_zero", ch_in_func[9], 1'h0);
   endtask
   task automatic t_out_sel;
      wr(gmia_pkg::IDX_OUT_SEL + 10'h3, 32'(gmia_pkg::OUT_SEL_LOW));
      settle(1);
      chk("out_low", pin_oe[3], 1'h1);
      wr(gmia_pkg::IDX_OUT_SEL + 10'h3, 32'(gmia_pkg::OUT_SEL_HIGH));
      settle(1);
      chk("out_high", pin_oe[3], 1'h0);
      wr(gmia_pkg::IDX_VOUT_SEL + 10'h8, 32'h2);
      wr(gmia_pkg::IDX_OUT_SEL + 10'h3, 32'(gmia_pkg::OUT_SEL_VOUT0 + 6'h8));
      settle(2);
      chk("out_vout", pin_oe[3], 1'h1);
      @(posedge core_clk);
      ch_out_func[18] <= 1'h1;
      settle(2);
      chk("out_vout", pin_oe[3], 1'h0);
      @(posedge core_clk);
      ch_out_func[18] <= 1'h0;
      wr(gmia_pkg::IDX_OUT_SEL + 10'h3, 32'(gmia_pkg::OUT_SEL_OFF));
      settle(1);
      chk("out_off", pin_oe[3], 1'h0);
   endtask
   task automatic t_change;
      wr(gmia_pkg::IDX_CHANGE_LO, 32'hFFFF_FFFF);
      wr(gmia_pkg::IDX_CHANGE_HI, 32'hFF);
      ext_low[7] <= 1'h1;
      settle(3);
      @(posedge core_clk);
      ext_low[7] <= 1'h0;
      settle(3);
      rdchk("chg_lo", gmia_pkg::IDX_CHANGE_LO, 32'h80);
      rdchk("chg_hi", gmia_pkg::IDX_CHANGE_HI, 32'h0);
      wr(gmia_pkg::IDX_CHANGE_LO, 32'h80);
      rdchk("chg_clr", gmia_pkg::IDX_CHANGE_LO, 32'h0);
      fork
         wr(gmia_pkg::IDX_CHANGE_LO, 32'h80);
         begin
            repeat (3) @(posedge core_clk);
            ext_low[7] <= 1'h1;
         end
      join
      rdchk("chg_set_wins", gmia_pkg::IDX_CHANGE_LO, 32'h80);
   endtask
   task automatic t_irq;
      ch_irq_src[19] <= 1'h1;
      wr(gmia_pkg::IDX_CH_EN + 10'h2, 32'h0800);
      rdchk("ch_st", gmia_pkg::IDX_CH_STATUS + 10'h2, 32'h0800);
      wr(gmia_pkg::IDX_AGG_EN + 10'h1, 32'h20);
      settle(2);
      chk("agg_ch", agg_irq, 4'h2);
      rdchk("agg_st", gmia_pkg::IDX_AGG_STATUS + 10'h1, 32'h20);
      wr(gmia_pkg::IDX_OUT_SEL + 10'h4, 32'(gmia_pkg::OUT_SEL_AGG0 + 6'h1));
      settle(2);
      chk("agg_pin", pin_oe[4], 1'h0);
      @(posedge core_clk);
      ch_irq_src[19] <= 1'h0;
      settle(3);
      chk("agg_ch", agg_irq, 4'h0);
      chk("agg_pin", pin_oe[4], 1'h1);
      wr(gmia_pkg::IDX_AGG_EN + 10'h3, 32'h1_8200);
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         {xconn_irq, timing_buf_status[3], timing_irq[1]} <= 3'h1 << i;
         settle(2);
         chk("agg_chip", agg_irq, 4'h8);
      end
      @(posedge core_clk);
      {xconn_irq, timing_buf_status[3], timing_irq[1]} <= 3'h0;
      ext_low[9] <= 1'h1;
      settle(3);
      chk("agg_pin_off", agg_irq, 4'h0);
      wr(gmia_pkg::IDX_PIN_IRQ_EN_LO, 32'h200);
      settle(2);
      chk("agg_pin_on", agg_irq, 4'hF);
      rdchk("agg_st2", gmia_pkg::IDX_AGG_STATUS + 10'h2, 32'h2_0000);
      wr(gmia_pkg::IDX_CHANGE_LO, 32'h200);
      settle(2);
      chk("agg_pin_clr", agg_irq, 4'h0);
   endtask
   task automatic t_err_reset;
      apb(1'h0, 10'h3FF, 32'h0);
      chk("unmapped_err", err, 1'h1);
      chk("unmapped_data", rd, 32'h0);
      @(posedge core_clk);
      nrst <= 1'h0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'h1;
      settle(1);
      chk("oe_rst2", pin_oe, 40'h0);
      chk("agg_rst2", agg_irq, 4'h0);
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'h1;
      t_defaults();
      t_in_sel();
      t_out_sel();
      t_change();
      t_irq();
      t_err_reset();
      conclude();
   end
endmodule
